// ### hdl/sleep_wake_pkg.sv
/*
  Constants shared by the sleep and wake controller and its timers.
  Assumes a 100 MHz pclk; times are converted to cycle counts here.
*/
package sleep_wake_pkg;
  localparam int unsigned       CLK_HZ            = 100000000;
  localparam int unsigned       PWRUP_DELAY_MS    = 72;
  localparam int unsigned       BROWNOUT_DELAY_MS = 72;
  localparam int unsigned       PWRUP_CYCLES      = PWRUP_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned       BROWNOUT_CYCLES   = BROWNOUT_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned       OSC_STARTUP_CYCLES = 1024;
  localparam int unsigned       WDT_PERIOD        = 1800;
  localparam int unsigned       CNT_W             = 24;
  localparam logic [12:0]       INT_VECTOR        = 13'h0004;
  localparam int unsigned       DUMMY_CYCLES      = 2;
  localparam int unsigned       NUM_INT           = 4;
  // Interrupt source positions in the enable and flag vectors
  localparam int unsigned       SRC_EXT           = 0;
  localparam int unsigned       SRC_PORT          = 1;
  localparam int unsigned       SRC_CMP           = 2;
  localparam int unsigned       SRC_TMR           = 3;
  localparam logic              PD_RESET          = 1'b1;
  localparam logic              TO_RESET          = 1'b1;

  typedef enum logic [2:0] {
    ST_RESET, ST_RUN, ST_SLEEP, ST_OSC_WAIT, ST_PREFETCH, ST_DUMMY
  } state_t;
endpackage

// ### hdl/delay_timer.sv
/*
  Reset-style delay counter: counts LIMIT cycles after start, then reports done.
  Assumes hold is a level that holds the timer at zero while high.
*/
module delay_timer #(
  parameter int unsigned W     = 24,
  parameter int unsigned LIMIT = 1000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hold,
  output logic      done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } dt_t;
  dt_t s_q;
  dt_t s_d;

  always_comb begin
    s_d = s_q;
    if (hold) begin
      s_d.cnt  = '0;
      s_d.done = 1'b0;
    end else if (!s_q.done) begin
      if (s_q.cnt >= W'(LIMIT - 1)) begin
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule // delay_timer

// ### hdl/watchdog_counter.sv
/*
  Watchdog counter on its own free-running tick. Clears on request.
  Assumes wdt_tick is a one-cycle pulse from the dedicated RC oscillator domain.
*/
module watchdog_counter #(
  parameter int unsigned W      = 24,
  parameter int unsigned PERIOD = 1800
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic wdt_tick,
  input  wire logic clear,
  output logic      timeout
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         timeout;
  } wd_t;
  wd_t s_q;
  wd_t s_d;

  always_comb begin
    s_d         = s_q;
    s_d.timeout = 1'b0;
    if (clear || !enable) begin
      s_d.cnt = '0;
    end else if (wdt_tick) begin
      if (s_q.cnt >= W'(PERIOD - 1)) begin
        s_d.cnt     = '0;
        s_d.timeout = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timeout = s_q.timeout;
endmodule // watchdog_counter

// ### hdl/sleep_wake_control.sv
/*
  Sleep entry, wake-up and reset sequencing for a small 8-bit core, with
  the power-up, oscillator start-up and brown-out delay timers and the
  watchdog. Registers sit on an APB slave.
  Assumes the core raises sleep_exec for one cycle when it executes the
  power-down instruction and obeys core_hold, vector_req and dummy_cycle.
*/
// Overview of operation
// [R1] Sleep entered only by the power-down instruction pulse.
// [R2] Sleep entry clears watchdog, clears power-down flag, sets time-out, stops oscillator.
// [R3] Port pin drive state frozen during sleep.
// [R4] Wake on master clear, enabled watchdog, or external, port, comparator interrupt.
// [R5] Master clear wake resets fully; watchdog and interrupt wakes resume.
// [R6] Power-down flag set at power-up; time-out flag cleared on watchdog wake.
// [R7] Next instruction prefetched during sleep and held until wake.
// [R8] Interrupt wake needs its enable bit, regardless of global enable.
// [R9] Global enable off continues in line; on branches to vector 0004h.
// [R10] Pending enabled interrupt at sleep request wakes immediately after instruction.
// [R11] Watchdog counter cleared on every wake-up.
// [R12] Watchdog time-out in sleep never drives master clear pin low.
// [R13] Power-up delay timer holds reset 72 ms at power-up only.
// [R14] Brown-out resets the device and holds reset at least 72 ms.
// [R15] Oscillator start-up timer holds reset until crystal stable.
// [R16] Watchdog enabled by configuration, clocked from its own RC oscillator.
// [R17] Software places a no-operation after power-down if needed.
// [R18] Master clear stays high during sleep unless reset intended.
// [R19] Timer module interrupt cannot wake the device.
// [R20] Two dummy cycles precede the vector instruction after interrupt wake.
// [R21] Crystal modes wait out oscillator start-up before resuming.
module sleep_wake_control
  import sleep_wake_pkg::*;
#(
  parameter int unsigned PWRUP_CNT    = sleep_wake_pkg::PWRUP_CYCLES,
  parameter int unsigned BROWNOUT_CNT = sleep_wake_pkg::BROWNOUT_CYCLES,
  parameter int unsigned OST_CNT      = sleep_wake_pkg::OSC_STARTUP_CYCLES,
  parameter int unsigned WDT_CNT      = sleep_wake_pkg::WDT_PERIOD,
  parameter int unsigned PORT_W       = 13
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     master_clear_pin_n,
  input  wire logic                     brownout_detect,
  input  wire logic                     wdt_enable_cfg,
  input  wire logic                     crystal_mode_cfg,
  input  wire logic                     wdt_tick,
  input  wire logic                     sleep_exec,
  input  wire logic [12:0]              pc_next,
  input  wire logic                     global_int_enable,
  input  wire logic [sleep_wake_pkg::NUM_INT-1:0] int_enable,
  input  wire logic [sleep_wake_pkg::NUM_INT-1:0] int_flag,
  input  wire logic [PORT_W-1:0]        port_out_in,
  input  wire logic [PORT_W-1:0]        port_oe_in,
  output logic      [PORT_W-1:0]        port_out,
  output logic      [PORT_W-1:0]        port_oe,
  output logic                          device_reset,
  output logic                          core_hold,
  output logic                          osc_enable,
  output logic                          prefetch_hold,
  output logic      [12:0]              prefetch_addr,
  output logic                          vector_req,
  output logic      [12:0]              vector_addr,
  output logic                          dummy_cycle,
  output logic                          power_down_flag,
  output logic                          timeout_flag,
  output logic                          sleeping
);
  import sleep_wake_pkg::*;

  localparam logic [11:0] STATUS_OFF = 12'h000;
  localparam logic [11:0] CTRL_OFF   = 12'h004;

  typedef struct packed {
    state_t              st;
    logic                pd;
    logic                to;
    logic [PORT_W-1:0]   pout;
    logic [PORT_W-1:0]   poe;
    logic [12:0]         pf_addr;
    logic                go_vector;
    logic [1:0]          dummy_cnt;
    logic                sw_wdt_clr;
    logic [31:0]         rdata;
    logic                first_run;
  } ctl_t;

  ctl_t s_q;
  ctl_t s_d;

  logic pwrup_done;
  logic bor_done;
  logic ost_done;
  logic wdt_timeout;
  logic wdt_clear;
  logic ost_hold;
  logic bor_hold;
  logic pending_wake;
  logic int_wake;
  logic wdt_wake;
  logic apb_acc;
  logic addr_ok;

  // Timer interrupt is excluded: that timer is stopped in sleep
  assign pending_wake = |(int_enable & int_flag & ~(NUM_INT'(1) << SRC_TMR)); // see [R8] [R19]
  assign int_wake     = pending_wake; // see [R4]
  assign wdt_wake     = wdt_timeout && wdt_enable_cfg; // see [R4]

  // Power-up timer runs once from reset release; brown-out restarts its own
  delay_timer #(
    .W     (CNT_W),
    .LIMIT (PWRUP_CNT)
  ) u_pwrup (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (1'b0),
    .done    (pwrup_done)
  ); // see [R13]

  assign bor_hold = brownout_detect;
  delay_timer #(
    .W     (CNT_W),
    .LIMIT (BROWNOUT_CNT)
  ) u_bor (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (bor_hold),
    .done    (bor_done)
  ); // see [R14]

  // Start-up timer restarts whenever the oscillator driver is off
  assign ost_hold = !s_q.first_run || (s_q.st == ST_SLEEP) || !master_clear_pin_n;
  delay_timer #(
    .W     (CNT_W),
    .LIMIT (OST_CNT)
  ) u_ost (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (ost_hold),
    .done    (ost_done)
  ); // see [R15]

  assign wdt_clear = (sleep_exec && s_q.st == ST_RUN) || s_q.sw_wdt_clr ||
                     (s_q.st == ST_SLEEP && (int_wake || wdt_wake)) ||
                     !master_clear_pin_n; // see [R2] [R11]
  watchdog_counter #(
    .W      (CNT_W),
    .PERIOD (WDT_CNT)
  ) u_wdt (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (wdt_enable_cfg),
    .wdt_tick (wdt_tick),
    .clear    (wdt_clear),
    .timeout  (wdt_timeout)
  ); // see [R16]

  assign apb_acc = psel && penable;
  assign addr_ok = (paddr == STATUS_OFF) || (paddr == CTRL_OFF);

  always_comb begin
    s_d            = s_q;
    s_d.sw_wdt_clr = 1'b0;
    s_d.first_run  = 1'b1;
    // Read data is captured in the setup phase so it stands at the access edge
    if (psel && !penable && !pwrite) begin
      if (paddr == STATUS_OFF) begin
        s_d.rdata = {26'h0, wdt_enable_cfg, s_q.st == ST_SLEEP, s_q.go_vector,
                     device_reset, s_q.to, s_q.pd};
      end else begin
        s_d.rdata = 32'h0;
      end
    end
    if (apb_acc && pwrite && paddr == CTRL_OFF && pwdata[0]) begin
      s_d.sw_wdt_clr = 1'b1;
    end
    case (s_q.st)
      ST_RESET: begin
        if (pwrup_done && bor_done && master_clear_pin_n &&
            (!crystal_mode_cfg || ost_done)) begin // see [R13] [R14] [R15]
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_exec) begin // see [R1]
          s_d.pd      = 1'b0; // see [R2] [R6]
          s_d.to      = 1'b1; // see [R2]
          s_d.pout    = port_out_in; // see [R3]
          s_d.poe     = port_oe_in; // see [R3]
          s_d.pf_addr = pc_next; // see [R7]
          s_d.st      = ST_SLEEP;
        end else if (wdt_wake) begin
          s_d.to = 1'b0;
          s_d.st = ST_RESET;
        end
      end
      ST_SLEEP: begin
        // Pending interrupts leave sleep on the first sleep cycle
        if (int_wake) begin // see [R10] [R8] [R5]
          s_d.go_vector = global_int_enable; // see [R9]
          s_d.st        = crystal_mode_cfg ? ST_OSC_WAIT : ST_PREFETCH;
        end else if (wdt_wake) begin // see [R12] [R5]
          s_d.to        = 1'b0; // see [R6]
          s_d.go_vector = 1'b0;
          s_d.st        = crystal_mode_cfg ? ST_OSC_WAIT : ST_PREFETCH;
        end
      end
      ST_OSC_WAIT: begin
        if (ost_done) begin // see [R21]
          s_d.st = ST_PREFETCH;
        end
      end
      ST_PREFETCH: begin
        // Prefetched instruction executes in this cycle
        if (s_q.go_vector) begin
          s_d.dummy_cnt = 2'(DUMMY_CYCLES);
          s_d.st        = ST_DUMMY;
        end else begin
          s_d.st = ST_RUN; // see [R9]
        end
      end
      ST_DUMMY: begin
        s_d.dummy_cnt = s_q.dummy_cnt - 2'd1; // see [R20]
        if (s_q.dummy_cnt == 2'd1) begin
          s_d.go_vector = 1'b0;
          s_d.st        = ST_RUN;
        end
      end
      default: begin
        s_d.st = ST_RESET;
      end
    endcase
    // External reset wins over everything, in sleep or running
    if (!master_clear_pin_n || brownout_detect) begin // see [R5] [R14]
      s_d.st        = ST_RESET;
      s_d.go_vector = 1'b0;
      s_d.dummy_cnt = 2'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.st   <= ST_RESET;
      s_q.pd   <= PD_RESET; // see [R6]
      s_q.to   <= TO_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign device_reset    = (s_q.st == ST_RESET);
  assign sleeping        = (s_q.st == ST_SLEEP) || (s_q.st == ST_OSC_WAIT);
  assign core_hold       = (s_q.st != ST_RUN) && (s_q.st != ST_PREFETCH);
  assign osc_enable      = (s_q.st != ST_SLEEP); // see [R2]
  assign prefetch_hold   = sleeping; // see [R7]
  assign prefetch_addr   = s_q.pf_addr;
  assign vector_req      = (s_q.st == ST_DUMMY) && (s_q.dummy_cnt == 2'd1); // see [R9]
  assign vector_addr     = INT_VECTOR;
  assign dummy_cycle     = (s_q.st == ST_DUMMY); // see [R20]
  assign power_down_flag = s_q.pd;
  assign timeout_flag    = s_q.to;
  // Frozen copy drives the pins while asleep
  assign port_out        = sleeping ? s_q.pout : port_out_in; // see [R3]
  assign port_oe         = sleeping ? s_q.poe : port_oe_in; // see [R3]

  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !addr_ok;
endmodule // sleep_wake_control

// ### testbench/sleep_wake_control_properties.sv
/*
  Port-level checker for the sleep and wake controller.
  Assumes binding onto the controller with shortened timer counts.
*/
module sleep_wake_control_properties
  import sleep_wake_pkg::*;
#(
  parameter int unsigned PWRUP_CNT = 20,
  parameter int unsigned PORT_W    = 13
) (
  input wire logic                               pclk,
  input wire logic                               presetn,
  input wire logic                               sleep_exec,
  input wire logic                               master_clear_pin_n,
  input wire logic                               brownout_detect,
  input wire logic                               wdt_enable_cfg,
  input wire logic                               crystal_mode_cfg,
  input wire logic [12:0]                        pc_next,
  input wire logic [sleep_wake_pkg::NUM_INT-1:0] int_enable,
  input wire logic [sleep_wake_pkg::NUM_INT-1:0] int_flag,
  input wire logic [PORT_W-1:0]                  port_out,
  input wire logic [PORT_W-1:0]                  port_oe,
  input wire logic                               device_reset,
  input wire logic                               core_hold,
  input wire logic                               osc_enable,
  input wire logic [12:0]                        prefetch_addr,
  input wire logic                               vector_req,
  input wire logic [12:0]                        vector_addr,
  input wire logic                               dummy_cycle,
  input wire logic                               power_down_flag,
  input wire logic                               timeout_flag,
  input wire logic                               sleeping
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic   wake_int = |(int_enable[2:0] & int_flag[2:0]);
  wire logic   quiet    = master_clear_pin_n && !brownout_detect;
  logic [31:0] up_q;
  logic [31:0] up_d;
  // Saturating count of cycles since reset release
  always_comb up_d = (up_q < PWRUP_CNT) ? up_q + 32'h1 : up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= '0;
    else up_q <= up_d;
  end
  sequence s_dummy_pair;
    dummy_cycle ##1 dummy_cycle && vector_req ##1 !dummy_cycle;
  endsequence
  a_sleep_entry: assert property (sleep_exec && !core_hold && !sleeping && quiet
    |=> sleeping && !osc_enable && !power_down_flag && timeout_flag) else $error("bad sleep entry");
  a_only_instr: assert property ($rose(sleeping) |-> $past(sleep_exec))
    else $error("sleep without instruction");
  a_prefetch_addr: assert property ($rose(sleeping) |-> prefetch_addr == $past(pc_next))
    else $error("prefetch address wrong");
  a_frozen_pins: assert property (sleeping && $past(sleeping)
    |-> $stable(port_out) && $stable(port_oe) && $stable(prefetch_addr)) else $error("pins moved");
  a_int_wake: assert property (sleeping && !osc_enable && wake_int && quiet
    |=> osc_enable) else $error("no interrupt wake");
  a_timer_no_wake: assert property (sleeping && !osc_enable && !wake_int && !wdt_enable_cfg
    && quiet |=> sleeping) else $error("spurious wake");
  a_ext_reset: assert property (!master_clear_pin_n || brownout_detect |=> device_reset)
    else $error("no reset");
  a_wdt_flag: assert property (sleeping && !wake_int && quiet ##1 !sleeping
    |-> !timeout_flag && !device_reset) else $error("watchdog wake flag");
  a_dummy_pair: assert property ($rose(dummy_cycle) |-> s_dummy_pair)
    else $error("dummy cycles wrong");
  a_vector_addr: assert property (vector_req |-> vector_addr == 13'h0004)
    else $error("vector address wrong");
  a_osc_wait: assert property ($rose(osc_enable) && sleeping && crystal_mode_cfg && quiet
    |-> (sleeping && core_hold) [*8]) else $error("start-up wait short");
  a_pwrup_hold: assert property (up_q < PWRUP_CNT - 2 |-> device_reset)
    else $error("power-up hold short");
endmodule // sleep_wake_control_properties

bind sleep_wake_control sleep_wake_control_properties #(
  .PWRUP_CNT(PWRUP_CNT),
  .PORT_W   (PORT_W)
) sleep_wake_control_properties_i (.*);

// ### testbench/core_model.sv
/*
  Model of the core and board: program counter, watchdog RC tick,
  master clear pin and random pin drive.
  Assumes the bench asks for an external reset through rst_req.
*/
module core_model (
  input  wire logic        pclk,
  input  wire logic        core_hold,
  input  wire logic        rst_req,
  output logic      [12:0] pc_next,
  output logic             wdt_tick,
  output logic             master_clear_pin_n,
  output logic      [12:0] port_out_in,
  output logic      [12:0] port_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int          seed = 32'hea1757fb;
  logic [1:0]  rc   = 2'h0;
  logic [12:0] pc   = 13'h0000;
  // Pin stays high unless a reset is meant
  assign master_clear_pin_n = !rst_req;
  // Word after the power-down instruction is taken as a no-operation
  assign pc_next = pc + 13'h0001;
  initial begin
    wdt_tick = 1'b0;
    port_out_in = '0;
    port_oe_in = '0;
  end
  always @(posedge pclk) begin
    // Own oscillator, keeps ticking while the core is stopped
    rc <= rc + 2'h1;
    wdt_tick <= (rc == 2'h2);
    if (!core_hold) pc <= pc + 13'h0001;
    port_out_in <= 13'($random(seed));
    port_oe_in <= 13'($random(seed));
  end
endmodule // core_model

// ### testbench/tb_top.sv
/*
  Self-checking bench for the sleep and wake controller.
  Assumes core_model as partner and the bound property checker.
*/
module tb_top
  import sleep_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PWR = 20;
  localparam int unsigned OSC_STARTUP_TIMER = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_req, err;
  logic        brownout_detect, wdt_enable_cfg, crystal_mode_cfg, sleep_exec;
  logic        global_int_enable, master_clear_pin_n, wdt_tick, device_reset, core_hold;
  logic        osc_enable, prefetch_hold, vector_req, dummy_cycle, sleeping;
  logic        power_down_flag, timeout_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  int_enable, int_flag;
  logic [12:0] pc_next, port_out_in, port_oe_in, port_out, port_oe, prefetch_addr, vector_addr;
  int          errors = 0, comparisons = 0, nvec, ndum, n, exp_pd, exp_to;

  sleep_wake_control #(.PWRUP_CNT(PWR), .BROWNOUT_CNT(PWR), .OST_CNT(OSC_STARTUP_TIMER), .WDT_CNT(10),
    .PORT_W(13)) sleep_wake_control_i (.*);
  core_model core_model_i (.*);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (vector_req === 1'b1) nvec++;
    if (dummy_cycle === 1'b1) ndum++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic flags();
    chk({power_down_flag, timeout_flag}, {exp_pd[0], exp_to[0]});
    apb(1'b0, 12'h000, '0);
    chk(rd[1:0], {exp_to[0], exp_pd[0]});
  endtask
  task automatic wait_run();
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (core_hold !== 1'b0 || device_reset !== 1'b0);
  endtask
  task automatic go_sleep();
    @(posedge pclk);
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    exp_pd = 0;
    exp_to = 1;
    #1;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, rst_req, brownout_detect} = '0;
    {wdt_enable_cfg, crystal_mode_cfg, sleep_exec, global_int_enable} = '0;
    {paddr, pwdata, int_enable, int_flag} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    exp_pd = 1;
    exp_to = 1;
    wait_run();
    chk(n >= PWR, 1);
    flags();
    apb(1'b0, 12'h010, '0);
    chk(err, 1);
    chk(rd, 0);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      int_flag <= '0;
      int_enable <= 4'h1 << (i % 3);
      global_int_enable <= (i >= 3);
      go_sleep();
      chk(sleeping, 1);
      flags();
      nvec = 0;
      ndum = 0;
      @(posedge pclk);
      int_flag <= 4'h1 << (i % 3);
      wait_run();
      repeat (4) @(posedge pclk);
      chk(ndum, (i >= 3) ? 2 : 0);
      chk(nvec, i >= 3);
    end
    @(posedge pclk);
    int_enable <= 4'h9;
    int_flag <= 4'h8;
    global_int_enable <= 1'b0;
    go_sleep();
    repeat (20) @(posedge pclk);
    #1 chk(sleeping, 1);
    @(posedge pclk);
    int_flag <= 4'h9;
    wait_run();
    go_sleep();
    wait_run();
    chk(n < 4, 1);
    @(posedge pclk);
    int_flag <= '0;
    crystal_mode_cfg <= 1'b1;
    go_sleep();
    @(posedge pclk);
    int_flag <= 4'h1;
    wait_run();
    chk(n > OSC_STARTUP_TIMER, 1);
    @(posedge pclk);
    int_flag <= '0;
    crystal_mode_cfg <= 1'b0;
    wdt_enable_cfg <= 1'b1;
    apb(1'b1, 12'h004, 32'h1);
    go_sleep();
    wait_run();
    chk(n > 36, 1);
    @(posedge pclk);
    wdt_enable_cfg <= 1'b0;
    exp_to = 0;
    flags();
    go_sleep();
    @(posedge pclk);
    rst_req <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(device_reset, 1);
    @(posedge pclk);
    rst_req <= 1'b0;
    wait_run();
    @(posedge pclk);
    brownout_detect <= 1'b1;
    @(posedge pclk);
    brownout_detect <= 1'b0;
    wait_run();
    chk(n >= PWR, 1);
    print_verdict();
  end
  // Whole sequence needs a few hundred cycles; this limit is generous
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
endmodule // tb_top
